//--- logic/cpu_ctl_pkg.sv
/*
 * Shared constants and carrier types for the CPU field protection,
 * clock and cold-start control block.
 * Assumes a single 40 MHz system clock and a synchronous active-high reset.
 */
package cpu_ctl_pkg;

    // Address and register widths
    localparam int ADDR_W = 22;
    localparam int FIELD_W = 18;
    localparam int FIELD_SHIFT = 4;
    localparam int XA_W = 8;
    localparam int PKG_ADDR_W = 12;
    localparam int CLOCK_W = 64;
    localparam int INTERVAL_W = 32;

    // Exchange timing in clock periods
    localparam int SWAP_CYCLES = 36;
    localparam int FETCH_CYCLES = 14;
    localparam int XCHG_CNT_W = 6;
    localparam logic [XCHG_CNT_W-1:0] SWAP_LOAD = 6'(SWAP_CYCLES - 1);
    localparam logic [XCHG_CNT_W-1:0] FETCH_LOAD = 6'(FETCH_CYCLES - 1);

    // Reset values
    localparam logic [XA_W-1:0] XA_RESET = 8'h00;
    localparam logic [FIELD_W-1:0] ORIGIN_RESET = 18'h00000;
    localparam logic [FIELD_W-1:0] LIMIT_RESET = 18'h00000;
    localparam logic [INTERVAL_W-1:0] RELOAD_RESET = 32'h00000000;
    localparam logic [ADDR_W-1:0] CHAN_ADDR_RESET = 22'h000000;

    // Instructions that reach this block from the issue stage
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_READ_CLOCK = 4'h1,    // 072: counter to scalar register
        OP_LOAD_CLOCK = 4'h2,    // 0014j0: scalar register to counter
        OP_LOAD_INTERVAL = 4'h3, // 0014j4
        OP_CLEAR_INT = 4'h4,     // 0014j5
        OP_ENABLE_INT = 4'h5,    // 0014j6
        OP_DISABLE_INT = 4'h6,   // 0014j7
        OP_SET_XA = 4'h7,        // A register to exchange address
        OP_EXIT = 4'h8           // normal or error exit
    } op_code_t;

    // Kinds of memory reference
    typedef enum logic [1:0] {
        REF_FETCH = 2'h0,
        REF_READ = 2'h1,
        REF_WRITE = 2'h2
    } ref_kind_t;

    // Exchange sequencer states
    typedef enum logic [1:0] {
        ST_HALT = 2'h0,
        ST_IDLE = 2'h1,
        ST_SWAP = 2'h2,
        ST_FETCH = 2'h3
    } xchg_state_t;

    typedef struct packed {
        ref_kind_t kind;
        logic [ADDR_W-1:0] addr;
    } mem_ref_t;

    typedef struct packed {
        logic [XA_W-1:0] xa;
        logic [FIELD_W-1:0] origin;
        logic [FIELD_W-1:0] limit;
        logic monitor;
        logic prog_err;
        logic oper_err;
    } xpkg_t;

endpackage : cpu_ctl_pkg

//--- logic/load_counter.sv
/*
 * Loadable free-running counter, counting up or down by one each clock.
 * Assumes the loader holds i_load for one cycle per load.
 */
`timescale 1ns/10ps
module load_counter #(
    parameter int WIDTH = 32,
    parameter bit COUNT_DOWN = 1'b0
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Load
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_value,
    // Count
    output logic [WIDTH-1:0] o_count
);

    logic [WIDTH-1:0] next_count;

    // Load takes priority over counting
    always_comb begin
        if (i_load) begin
            next_count = i_load_value;
        end else if (COUNT_DOWN) begin
            next_count = o_count - WIDTH'(1);
        end else begin
            next_count = o_count + WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_count <= '0;
        end else begin
            o_count <= next_count;
        end
    end

endmodule : load_counter

//--- logic/cpu_field_protect_clocks_boot.sv
/*
 * Field protection, cycle counter, interval interrupt and cold-start
 * exchange control for the CPU.
 * Assumes issue, memory and package datapaths outside; master clear and
 * I/O clear come asynchronously from the maintenance controller.
 */
`timescale 1ns/10ps
module cpu_field_protect_clocks_boot
    import cpu_ctl_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Maintenance controller
    input wire logic i_master_clear,
    input wire logic i_io_clear,
    input wire logic i_mcu_word,
    output logic o_mcu_chan_active,
    output logic [ADDR_W-1:0] o_mcu_chan_addr,
    // Instruction port
    input wire logic i_op_valid,
    input wire op_code_t i_op_code,
    input wire logic [CLOCK_W-1:0] i_op_operand,
    output logic o_read_valid,
    output logic [CLOCK_W-1:0] o_read_data,
    output logic o_issue_hold,
    // Memory reference port
    input wire logic i_ref_valid,
    input wire mem_ref_t i_ref,
    output logic o_mem_req,
    output logic o_mem_write,
    output logic o_read_zero,
    output logic [ADDR_W-1:0] o_mem_addr,
    // Exchange package port
    input wire xpkg_t i_pkg_in,
    output logic o_xchg_store,
    output logic o_xchg_load,
    output logic [PKG_ADDR_W-1:0] o_xchg_addr,
    output xpkg_t o_pkg_out,
    // Status
    output logic o_monitor,
    output logic o_prog_range_err,
    output logic o_oper_range_err,
    output logic o_interval_req,
    output logic [CLOCK_W-1:0] o_cycle_count
);

    // Three-stage synchronisers for the controller levels
    logic [2:0] mc_sync;
    logic [2:0] ioc_sync;
    logic mc_level;
    logic ioc_level;
    logic next_mc_level;
    logic next_ioc_level;

    // Control state
    xchg_state_t state, next_state;
    logic [XCHG_CNT_W-1:0] xcnt, next_xcnt;
    logic [XA_W-1:0] xa, next_xa;
    logic [FIELD_W-1:0] origin, next_origin;
    logic [FIELD_W-1:0] limit, next_limit;
    logic [INTERVAL_W-1:0] reload, next_reload;
    logic int_enable, next_int_enable;
    logic next_monitor, next_prog_err, next_oper_err, next_int_req;
    logic next_mcu_active;
    logic [ADDR_W-1:0] next_mcu_addr;
    logic next_read_valid, next_issue_hold;
    logic [CLOCK_W-1:0] next_read_data;
    logic next_mem_req, next_mem_write, next_read_zero;
    logic [ADDR_W-1:0] next_mem_addr;
    logic next_store, next_load;
    xpkg_t next_pkg_out;

    // Helpers
    logic [INTERVAL_W-1:0] countdown;
    logic accept;
    logic op_sup;
    logic [ADDR_W:0] abs_addr;
    logic in_bounds;
    logic xchg_req;

    // Counters
    logic clock_load;
    logic countdown_load;
    logic [INTERVAL_W-1:0] countdown_value;

    // Issue is accepted only while idle and not master cleared
    assign accept = (state == ST_IDLE) && !mc_level;
    assign op_sup = accept && i_op_valid && o_monitor;
    assign clock_load = op_sup && (i_op_code == OP_LOAD_CLOCK);
    assign countdown_load = (op_sup && (i_op_code == OP_LOAD_INTERVAL))
        || (countdown == '0);
    assign countdown_value = (op_sup && (i_op_code == OP_LOAD_INTERVAL))
        ? i_op_operand[INTERVAL_W-1:0] : reload;

    // Origin is shifted up four bits; overflow bit catches wraparound
    assign abs_addr = {1'b0, i_ref.addr} + {1'b0, origin, 4'h0};
    assign in_bounds = abs_addr < {1'b0, limit, 4'h0};

    // Interrupt sources start an exchange only from user mode
    assign xchg_req = o_prog_range_err || o_oper_range_err
        || (o_interval_req && !o_monitor)
        || (i_op_valid && i_op_code == OP_EXIT);

    load_counter #(.WIDTH(CLOCK_W), .COUNT_DOWN(1'b0)) u_cycle (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_load(clock_load),
        .i_load_value(i_op_operand),
        .o_count(o_cycle_count)
    );

    load_counter #(.WIDTH(INTERVAL_W), .COUNT_DOWN(1'b1)) u_countdown (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_load(countdown_load),
        .i_load_value(countdown_value),
        .o_count(countdown)
    );

    // A level counts once the second and third stages agree
    always_comb begin
        next_mc_level = (mc_sync[1] == mc_sync[2]) ? mc_sync[2] : mc_level;
        next_ioc_level = (ioc_sync[1] == ioc_sync[2]) ? ioc_sync[2] : ioc_level;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            // Held in clear through reset, so a held pin cannot look like a release
            mc_sync <= 3'h7;
            ioc_sync <= 3'h0;
            mc_level <= 1'b1;
            ioc_level <= 1'b0;
        end else begin
            mc_sync <= {mc_sync[1:0], i_master_clear};
            ioc_sync <= {ioc_sync[1:0], i_io_clear};
            mc_level <= next_mc_level;
            ioc_level <= next_ioc_level;
        end
    end

    // Next values for sequencer, registers, flags and outputs
    always_comb begin
        next_state = state;
        next_xcnt = xcnt;
        next_xa = xa;
        next_origin = origin;
        next_limit = limit;
        next_reload = reload;
        next_int_enable = int_enable;
        next_monitor = o_monitor;
        next_prog_err = o_prog_range_err;
        next_oper_err = o_oper_range_err;
        next_int_req = o_interval_req;
        next_mcu_active = o_mcu_chan_active;
        next_mcu_addr = o_mcu_chan_addr;
        next_read_valid = 1'b0;
        next_read_data = o_read_data;
        next_mem_req = 1'b0;
        next_mem_write = 1'b0;
        next_read_zero = 1'b0;
        next_mem_addr = o_mem_addr;
        next_store = 1'b0;
        next_load = 1'b0;
        next_pkg_out = o_pkg_out;
        next_issue_hold = 1'b1;

        // Maintenance channel: I/O clear wins over a word advance
        if (ioc_level) begin
            next_mcu_addr = CHAN_ADDR_RESET;
            next_mcu_active = 1'b1;
        end else if (o_mcu_chan_active && i_mcu_word) begin
            next_mcu_addr = o_mcu_chan_addr + ADDR_W'(1);
        end

        // Clear opcode, then hardware set wins in the same cycle
        if (op_sup && i_op_code == OP_CLEAR_INT) begin
            next_int_req = 1'b0;
        end
        if (op_sup && i_op_code == OP_ENABLE_INT) begin
            next_int_enable = 1'b1;
        end
        if (op_sup && i_op_code == OP_DISABLE_INT) begin
            next_int_enable = 1'b0;
        end
        if (op_sup && i_op_code == OP_LOAD_INTERVAL) begin
            next_reload = i_op_operand[INTERVAL_W-1:0];
        end
        if (op_sup && i_op_code == OP_SET_XA) begin
            next_xa = i_op_operand[XA_W-1:0];
        end
        if (accept && i_op_valid && i_op_code == OP_READ_CLOCK) begin
            next_read_valid = 1'b1;
            next_read_data = o_cycle_count;
        end
        if (countdown == '0 && int_enable) begin
            next_int_req = 1'b1;
        end

        // Field check; writes suppressed, reads zeroed when out of field
        if (accept && i_ref_valid) begin
            next_mem_req = 1'b1;
            next_mem_addr = abs_addr[ADDR_W-1:0];
            next_mem_write = (i_ref.kind == REF_WRITE) && in_bounds;
            next_read_zero = (i_ref.kind != REF_WRITE) && !in_bounds;
            if (!in_bounds && !o_monitor) begin
                if (i_ref.kind == REF_FETCH) begin
                    next_prog_err = 1'b1;
                end else begin
                    next_oper_err = 1'b1;
                end
            end
        end

        case (state)
            ST_HALT: begin
                // Released master clear exchanges from package zero
                if (!mc_level) begin
                    next_state = ST_SWAP;
                    next_xcnt = SWAP_LOAD;
                    next_store = 1'b1;
                    next_pkg_out = '{xa, origin, limit, o_monitor, 1'b0, 1'b0};
                end
            end
            ST_IDLE: begin
                next_issue_hold = 1'b0;
                if (xchg_req) begin
                    next_state = ST_SWAP;
                    next_xcnt = SWAP_LOAD;
                    next_issue_hold = 1'b1;
                    next_store = 1'b1;
                    next_pkg_out = '{xa, origin, limit, o_monitor,
                                     o_prog_range_err, o_oper_range_err};
                end
            end
            ST_SWAP: begin
                if (xcnt == '0) begin
                    next_state = ST_FETCH;
                    next_xcnt = FETCH_LOAD;
                    next_load = 1'b1;
                    next_xa = i_pkg_in.xa;
                    next_origin = i_pkg_in.origin;
                    next_limit = i_pkg_in.limit;
                    next_monitor = i_pkg_in.monitor;
                    next_prog_err = i_pkg_in.prog_err;
                    next_oper_err = i_pkg_in.oper_err;
                end else begin
                    next_xcnt = xcnt - XCHG_CNT_W'(1);
                end
            end
            ST_FETCH: begin
                if (xcnt == '0) begin
                    next_state = ST_IDLE;
                    next_issue_hold = 1'b0;
                end else begin
                    next_xcnt = xcnt - XCHG_CNT_W'(1);
                end
            end
            default: begin
                next_state = ST_HALT;
            end
        endcase

        // Master clear overrides the sequencer, mode, error flags and strobes and forces known latches
        if (mc_level) begin
            next_state = ST_HALT;
            next_xcnt = '0;
            next_xa = XA_RESET;
            next_monitor = 1'b1;
            next_prog_err = 1'b0;
            next_oper_err = 1'b0;
            next_issue_hold = 1'b1;
            next_mem_req = 1'b0;
            next_mem_write = 1'b0;
            next_read_zero = 1'b0;
            next_read_valid = 1'b0;
            next_store = 1'b0;
            next_load = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= ST_HALT;
            xcnt <= '0;
            xa <= XA_RESET;
            origin <= ORIGIN_RESET;
            limit <= LIMIT_RESET;
            reload <= RELOAD_RESET;
            int_enable <= 1'b0;
            o_monitor <= 1'b1;
            o_prog_range_err <= 1'b0;
            o_oper_range_err <= 1'b0;
            o_interval_req <= 1'b0;
            o_mcu_chan_active <= 1'b0;
            o_mcu_chan_addr <= CHAN_ADDR_RESET;
            o_read_valid <= 1'b0;
            o_read_data <= '0;
            o_issue_hold <= 1'b1;
            o_mem_req <= 1'b0;
            o_mem_write <= 1'b0;
            o_read_zero <= 1'b0;
            o_mem_addr <= '0;
            o_xchg_store <= 1'b0;
            o_xchg_load <= 1'b0;
            o_xchg_addr <= '0;
            o_pkg_out <= '0;
        end else begin
            state <= next_state;
            xcnt <= next_xcnt;
            xa <= next_xa;
            origin <= next_origin;
            limit <= next_limit;
            reload <= next_reload;
            int_enable <= next_int_enable;
            o_monitor <= next_monitor;
            o_prog_range_err <= next_prog_err;
            o_oper_range_err <= next_oper_err;
            o_interval_req <= next_int_req;
            o_mcu_chan_active <= next_mcu_active;
            o_mcu_chan_addr <= next_mcu_addr;
            o_read_valid <= next_read_valid;
            o_read_data <= next_read_data;
            o_issue_hold <= next_issue_hold;
            o_mem_req <= next_mem_req;
            o_mem_write <= next_mem_write;
            o_read_zero <= next_read_zero;
            o_mem_addr <= next_mem_addr;
            o_xchg_store <= next_store;
            o_xchg_load <= next_load;
            o_xchg_addr <= {next_xa, 4'h0};
            o_pkg_out <= next_pkg_out;
        end
    end

    // Exchange lasts 36 swap cycles then 14 fetch cycles
    AST_XCHG_LEN: assert property (@(posedge i_clk_sys) disable iff (i_rst || mc_level)
        (state == ST_IDLE ##1 state == ST_SWAP) |->
            ##36 (state == ST_FETCH) ##14 (state == ST_IDLE))
        else $error("exchange length wrong");

    AST_WRITE_GATE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (accept && i_ref_valid && i_ref.kind == REF_WRITE && !in_bounds)
            |=> (o_mem_req && !o_mem_write))
        else $error("out-of-field write reached memory");

    AST_READ_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (accept && i_ref_valid && i_ref.kind == REF_READ && !in_bounds) |=> o_read_zero)
        else $error("out-of-field read not zeroed");

    AST_PROG_ERR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (accept && i_ref_valid && i_ref.kind == REF_FETCH && !in_bounds && !o_monitor)
            |=> o_prog_range_err ##[1:2] o_issue_hold)
        else $error("fetch range error missed");

    AST_OPER_ERR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (accept && i_ref_valid && i_ref.kind != REF_FETCH && !in_bounds && !o_monitor)
            |=> o_oper_range_err)
        else $error("operand range error missed");

    AST_CYCLE_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !clock_load |=> (o_cycle_count == $past(o_cycle_count) + 64'h1))
        else $error("cycle counter did not advance");

    AST_COUNTDOWN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (countdown == '0 && !(op_sup && i_op_code == OP_LOAD_INTERVAL))
            |=> (countdown == $past(reload)))
        else $error("countdown did not reload");

    AST_COUNT_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (countdown != '0 && !countdown_load) |=> (countdown == $past(countdown) - 32'h1))
        else $error("countdown did not step down");

    AST_INT_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_interval_req && !(op_sup && i_op_code == OP_CLEAR_INT)) |=> o_interval_req)
        else $error("interval request dropped");

    AST_INT_DISABLED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!int_enable && !o_interval_req) |=> !o_interval_req)
        else $error("interval request set while disabled");

    AST_COLD_XA: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mc_level |=> (xa == XA_RESET && state == ST_HALT))
        else $error("master clear did not force exchange address");

    AST_IO_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ioc_level |=> (o_mcu_chan_active && o_mcu_chan_addr == CHAN_ADDR_RESET))
        else $error("I/O clear did not reset channel");

endmodule : cpu_field_protect_clocks_boot

//--- testbench/mcu_model.sv
/* Maintenance controller model: cold-start sequence and package source.
   Assumes the block's store pulse marks the first swap cycle. */
`timescale 1ns/10ps
module mcu_model
    import cpu_ctl_pkg::*;
(
    // Clock and block side
    input wire logic i_clk_sys,
    input wire logic i_xchg_store,
    input wire xpkg_t i_next_pkg,
    // Controls and package words
    output logic o_master_clear,
    output logic o_io_clear,
    output logic o_mcu_word,
    output logic o_loaded,
    output xpkg_t o_pkg
);
    logic [5:0] swap_cnt = 6'h00;

    // Swap cycle count since the store pulse
    always_ff @(posedge i_clk_sys) begin
        if (i_xchg_store) begin
            swap_cnt <= 6'h01;
        end else if (swap_cnt != 6'h00) begin
            swap_cnt <= swap_cnt + 6'h01;
        end
    end

    // Words valid only near the sample point, so a late sample sees junk
    assign o_pkg = (swap_cnt >= 6'h22 && swap_cnt <= 6'h24) ? i_next_pkg : ~i_next_pkg;

    // Clear on, I/O clear pulse, memory load, clear off
    initial begin
        o_master_clear = 1'b1;
        o_io_clear = 1'b0;
        o_mcu_word = 1'b0;
        o_loaded = 1'b0;
        repeat (8) @(negedge i_clk_sys);
        o_io_clear = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        o_io_clear = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        repeat (4) begin
            o_mcu_word = 1'b1;
            @(negedge i_clk_sys);
            o_mcu_word = 1'b0;
            @(negedge i_clk_sys);
        end
        o_loaded = 1'b1;
        @(negedge i_clk_sys);
        o_master_clear = 1'b0;
    end
endmodule : mcu_model

//--- testbench/cpu_field_protect_clocks_boot_bench.sv
/* Self-checking bench for the protection, clock and cold-start block.
   Assumes the maintenance model drives the clear lines and package words. */
`timescale 1ns/10ps
module cpu_field_protect_clocks_boot_bench import cpu_ctl_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_v = 1'b0;
    op_code_t op = OP_NONE;
    logic [63:0] opnd = 64'h0;
    logic ref_v = 1'b0;
    mem_ref_t rf = '{REF_FETCH, 22'h000000};
    xpkg_t npkg = '{8'h00, 18'h00000, 18'h00000, 1'b1, 1'b0, 1'b0};
    xpkg_t pin, pout;
    logic mc, ioc, word, loaded, rd_v, hold, mreq, mwr, rz, pe, oe, ireq, mon, act, st, ld;
    logic [21:0] caddr, maddr;
    logic [11:0] xaddr;
    logic [63:0] rd, v, cnt;
    logic [63:0] expq[$];
    logic [17:0] org, lim;
    int ivl;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    mcu_model mcu (.i_clk_sys(clk), .i_xchg_store(st), .i_next_pkg(npkg), .o_master_clear(mc),
        .o_io_clear(ioc), .o_mcu_word(word), .o_loaded(loaded), .o_pkg(pin));
    cpu_field_protect_clocks_boot uut (.i_clk_sys(clk), .i_rst(rst), .i_master_clear(mc),
        .i_io_clear(ioc), .i_mcu_word(word), .o_mcu_chan_active(act), .o_mcu_chan_addr(caddr),
        .i_op_valid(op_v), .i_op_code(op), .i_op_operand(opnd), .o_read_valid(rd_v),
        .o_read_data(rd), .o_issue_hold(hold), .i_ref_valid(ref_v), .i_ref(rf), .o_mem_req(mreq),
        .o_mem_write(mwr), .o_read_zero(rz), .o_mem_addr(maddr), .i_pkg_in(pin),
        .o_xchg_store(st), .o_xchg_load(ld), .o_xchg_addr(xaddr), .o_pkg_out(pout),
        .o_monitor(mon), .o_prog_range_err(pe), .o_oper_range_err(oe), .o_interval_req(ireq),
        .o_cycle_count(cnt));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // One-cycle instruction strobe, spaced so the strobe never toggles twice
    task automatic issue(input op_code_t c, input logic [63:0] d);
        @(negedge clk);
        op_v = 1'b1;
        op = c;
        opnd = d;
        @(negedge clk);
        op_v = 1'b0;
    endtask : issue

    task automatic mref(input int k, input logic [21:0] a, input logic [23:0] e);
        expq.push_back({40'h0, e});
        @(negedge clk);
        ref_v = 1'b1;
        rf = '{ref_kind_t'(k), a};
        @(negedge clk);
        ref_v = 1'b0;
    endtask : mref

    // Bounded wait on hold (sel 0) or interval request (sel 1)
    task automatic wait_for(input bit sel, input logic lvl, input int lo, input int hi);
        int i;
        i = 0;
        while ((sel ? ireq : hold) !== lvl && i <= hi) begin
            @(negedge clk);
            i++;
        end
        check(64'(i >= lo && i <= hi), 64'h1);
    endtask : wait_for

    // Results pop the oldest note; sampled at the edge so pulses are not missed
    always @(posedge clk) begin
        if (rd_v === 1'b1 || mreq === 1'b1) begin
            if (expq.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                check(rd_v ? rd : {40'h0, mwr, rz, maddr}, expq.pop_front());
            end
        end
    end

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        void'($urandom(10));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        wait (loaded === 1'b1);
        check({hold, act, 40'h0, caddr}, {1'b1, 1'b1, 40'h0, 22'h000004});
        wait_for(0, 1'b0, 0, 80);
        check({mon, 51'h0, xaddr}, {1'b1, 51'h0, 12'h000});
        // Counter load then two reads nine cycles apart
        v = {$urandom, $urandom};
        issue(OP_LOAD_CLOCK, v);
        check(cnt, v);
        expq.push_back(v + 64'h1);
        issue(OP_READ_CLOCK, 64'h0);
        repeat (7) @(negedge clk);
        expq.push_back(v + 64'ha);
        issue(OP_READ_CLOCK, 64'h0);
        // Interval request: silent until enabled, then sticky, pending in monitor mode
        ivl = 6 + $urandom_range(6);
        issue(OP_LOAD_INTERVAL, 64'(ivl));
        issue(OP_CLEAR_INT, 64'h0);
        repeat (30) @(negedge clk);
        check(64'(ireq), 64'h0);
        issue(OP_ENABLE_INT, 64'h0);
        wait_for(1, 1'b1, 0, ivl + 3);
        repeat (25) @(negedge clk);
        check(64'({ireq, hold}), 64'h2);
        issue(OP_DISABLE_INT, 64'h0);
        issue(OP_CLEAR_INT, 64'h0);
        repeat (30) @(negedge clk);
        check(64'(ireq), 64'h0);
        // User field: boundary in-field refs, then one out-of-field ref of each kind
        org = 18'(16 + $urandom_range(15));
        lim = org + 18'h20;
        for (int k = 0; k < 3; k++) begin
            npkg = '{8'h00, org, lim, 1'b0, 1'b0, 1'b0};
            issue(OP_SET_XA, 64'(k + 1));
            issue(OP_EXIT, 64'h0);
            wait_for(0, 1'b1, 0, 4);
            check({xaddr, 5'h0, pout}, {8'(k + 1), 4'h0, 5'h0, 8'(k + 1), 36'h0, 3'h4});
            // Load pulse lands one cycle after the last swap cycle
            repeat (36) @(negedge clk);
            check(64'(ld), 64'h1);
            wait_for(0, 1'b0, 11, 16);
            check(64'(mon), 64'h0);
            npkg = '{8'h00, 18'h00000, 18'h00000, 1'b1, 1'b0, 1'b0};
            mref(1, {lim - org, 4'h0} - 22'h1, {2'b00, {lim, 4'h0} - 22'h1});
            mref(2, 22'h0, {2'b10, org, 4'h0});
            mref(k, {lim - org, 4'h0}, {1'b0, k != 2, lim, 4'h0});
            check(64'({pe, oe}), (k == 0) ? 64'h2 : 64'h1);
            wait_for(0, 1'b1, 0, 3);
            check({xaddr, 5'h0, pout}, {17'h0, 8'h00, org, lim, 1'b0, k == 0, k != 0});
            wait_for(0, 1'b0, 47, 52);
            check(64'(mon), 64'h1);
        end
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule : cpu_field_protect_clocks_boot_bench
